// [include/lcb_pkg.sv]
// Shared constants and types for the local bus to audio codec bridge.
// Assumes one clock for both ends; codec pins are asynchronous to it.
package lcb_pkg;
  // Address fields used by the partial decoder.
  localparam int RGN_HI = 31;
  localparam int RGN_LO = 28;
  localparam int SEL_HI = 4;
  localparam int SEL_LO = 3;
  localparam int MONO_BIT = 0;
  localparam int LOW_HI = 2;
  // Region codes carried in the top address nibble.
  localparam logic [3:0] RGN_DMA = 4'h4;
  localparam logic [3:0] RGN_REG = 4'h5;
  localparam logic [3:0] RGN_PDN = 4'h6;
  localparam logic [3:0] RGN_PUP = 4'h7;
  // Codec register selects, physical low address divided by eight.
  localparam logic [1:0] SEL_INDEX = 2'h0;
  localparam logic [1:0] SEL_IDATA = 2'h1;
  localparam logic [1:0] SEL_STATUS = 2'h2;
  localparam logic [1:0] SEL_PIO = 2'h3;
  // Low address bits flipped by the processor in little-endian mode.
  localparam logic [2:0] LE_BYTE_XOR = 3'h7;
  localparam logic [2:0] LE_HALF_XOR = 3'h6;
  // Codec cycle phases in bus clocks.
  localparam logic [3:0] SETUP_CYC = 4'h1;
  localparam logic [3:0] STROBE_CYC = 4'hd;
  localparam logic [3:0] HOLD_CYC = 4'h7;
  // Transfer size on the processor bus.
  typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD} lcb_size_e;
  // Commands accepted by the bus master end.
  typedef enum logic [2:0] {CMD_REG_RD, CMD_REG_WR, CMD_PAIR_RD, CMD_PAIR_WR, CMD_PWR_DN, CMD_PWR_UP} lcb_cmd_e;
endpackage

// [include/lcb_bus_if.sv]
// Processor local bus between the bus master end and the bridge end.
// Assumes both ends share clk; the bench joins them through this interface.
interface lcb_bus_if
  import lcb_pkg::*;
(
  input wire logic clk
);
  logic ts;
  logic [31:0] addr;
  lcb_size_e size;
  logic write;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic aack;
  logic ta;
  logic bus_transfer_error;
  logic irq_n;
  logic [2:0] irq_src;
  // Bridge end of the bus.
  modport bridge (input clk, ts, addr, size, write, wdata, output rdata, aack, ta, bus_transfer_error, irq_n, irq_src);
  // Processor end of the bus.
  modport master (input clk, rdata, aack, ta, bus_transfer_error, irq_n, irq_src, output ts, addr, size, write, wdata);
endinterface

// [hdl/lcb_bridge.sv]
// Bridge end: decodes processor accesses into codec register and DMA cycles.
// Assumes codec pins are asynchronous and the master keeps stereo pairs together.
// Functional notes
// - Each DMA request rise raises an interrupt.
// - Region four accesses become codec DMA cycles.
// - Half-word load captures, half-word store plays.
// - Master sends stereo pair as two halves.
// - Intruding register or opposite-direction DMA access between halves gets transfer error.
// - Capture and playback use separate acknowledges.
// - Mono byte DMA unsupported; answered with error.
// - Region six access asserts codec power-down low.
// - Hard reset asserts codec power-down low.
// - Only region seven access releases power-down.
// - Region five byte accesses reach codec registers.
// - Decode is partial; locations alias within each region.
// - Little-endian software flips low address bits.
// - Software uses byte and half-word widths; the master issues power-down and release accesses as words.
// - Low sample byte goes to codec first.
// - Three sources merge onto one interrupt, identified.
module lcb_bridge
  import lcb_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  lcb_bus_if.bridge bus,
  input wire logic [7:0] codec_data_in,
  output logic [7:0] codec_data_out,
  output logic codec_data_oe,
  output logic [1:0] codec_addr,
  output logic codec_cs_n,
  output logic codec_rd_n,
  output logic codec_wr_n,
  output logic capture_dma_ack_n,
  output logic playback_dma_ack_n,
  output logic codec_power_down_n,
  input wire logic capture_dma_request,
  input wire logic playback_dma_request,
  input wire logic codec_int
);
  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD} lcb_br_state_e;

  typedef struct packed {
    lcb_br_state_e st;
    logic [3:0] cnt;
    logic dma;
    logic wr;
    logic byte_i;
    logic mid_pair;
    logic pair_wr;
    logic [15:0] wbuf;
    logic [15:0] rbuf;
    logic [10:0] s1;
    logic [10:0] s2;
    logic [1:0] prv;
    logic [1:0] pend;
    logic [7:0] dout;
    logic doe;
    logic [1:0] caddr;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic cak_n;
    logic pak_n;
    logic pd_n;
    logic aack;
    logic ta;
    logic bus_transfer_error;
    logic [31:0] rdata;
    logic irq_n;
    logic [2:0] src;
  } lcb_br_s;

  // Hard reset parks everything idle and holds the codec powered down.
  localparam lcb_br_s RST_VAL = '{st: ST_IDLE, cnt: 4'h0, dma: 1'b0, wr: 1'b0, byte_i: 1'b0,
    mid_pair: 1'b0, pair_wr: 1'b0, wbuf: 16'h0000, rbuf: 16'h0000, s1: 11'h000, s2: 11'h000,
    prv: 2'h0, pend: 2'h0, dout: 8'h00, doe: 1'b0, caddr: 2'h0, cs_n: 1'b1, rd_n: 1'b1,
    wr_n: 1'b1, cak_n: 1'b1, pak_n: 1'b1, pd_n: 1'b0, aack: 1'b0, ta: 1'b0, bus_transfer_error: 1'b0,
    rdata: 32'h0000_0000, irq_n: 1'b1, src: 3'h0};

  lcb_br_s q;
  lcb_br_s d;
  logic [3:0] rgn;
  logic [1:0] rise;
  logic [1:0] clr;

  assign rgn = bus.addr[RGN_HI:RGN_LO];

  // Next-state logic for decode, codec sequencing, power control and interrupts.
  always_comb
  begin
    d = q;
    clr = 2'h0;
    d.aack = 1'b0;
    d.ta = 1'b0;
    d.bus_transfer_error = 1'b0;
    // Two flip-flops on every codec pin before anything looks at it.
    d.s1 = {codec_int, playback_dma_request, capture_dma_request, codec_data_in};
    d.s2 = q.s1;
    unique case (q.st)
      ST_IDLE:
      begin
        if (bus.ts)
        begin
          // Only the region nibble, register select and low bit are decoded.
          unique case (rgn)
            RGN_PDN:
            begin
              d.pd_n = 1'b0;
              d.aack = 1'b1;
              d.ta = 1'b1;
            end
            RGN_PUP:
            begin
              d.pd_n = 1'b1;
              d.aack = 1'b1;
              d.ta = 1'b1;
            end
            RGN_REG:
            begin
              // A register access between pair halves would corrupt the stereo frame.
              if (q.mid_pair || bus.size != SZ_BYTE)
              begin
                d.aack = 1'b1;
                d.bus_transfer_error = 1'b1;
              end
              else
              begin
                d.st = ST_SETUP;
                d.cnt = SETUP_CYC - 4'h1;
                d.dma = 1'b0;
                d.wr = bus.write;
                d.byte_i = 1'b0;
                d.caddr = bus.addr[SEL_HI:SEL_LO];
                d.cs_n = 1'b0;
                d.dout = bus.wdata[7:0];
                d.doe = bus.write;
              end
            end
            RGN_DMA:
            begin
              if (bus.size != SZ_HALF || bus.addr[MONO_BIT] || (q.mid_pair && bus.write != q.pair_wr))
              begin
                d.aack = 1'b1;
                d.bus_transfer_error = 1'b1;
              end
              else
              begin
                d.st = ST_SETUP;
                d.cnt = SETUP_CYC - 4'h1;
                d.dma = 1'b1;
                d.wr = bus.write;
                d.byte_i = 1'b0;
                d.wbuf = bus.wdata[15:0];
                d.dout = bus.wdata[7:0];
                d.doe = bus.write;
                // Separate acknowledge per direction gives dual-channel operation.
                d.cak_n = bus.write;
                d.pak_n = ~bus.write;
                clr = bus.write ? 2'h2 : 2'h1;
              end
            end
            default:
            begin
              d.st = ST_IDLE;
            end
          endcase
        end
      end
      ST_SETUP:
      begin
        d.cnt = q.cnt - 4'h1;
        if (q.cnt == 4'h0)
        begin
          d.st = ST_STROBE;
          d.cnt = STROBE_CYC - 4'h1;
          d.rd_n = q.wr;
          d.wr_n = ~q.wr;
        end
      end
      ST_STROBE:
      begin
        d.cnt = q.cnt - 4'h1;
        if (q.cnt == 4'h0)
        begin
          d.st = ST_HOLD;
          d.cnt = HOLD_CYC - 4'h1;
          d.rd_n = 1'b1;
          d.wr_n = 1'b1;
          if (q.byte_i)
            d.rbuf[15:8] = q.s2[7:0];
          else
            d.rbuf[7:0] = q.s2[7:0];
        end
      end
      ST_HOLD:
      begin
        d.cnt = q.cnt - 4'h1;
        if (q.cnt == 4'h0)
        begin
          if (q.dma && !q.byte_i)
          begin
            // Second byte of the half-word follows the first.
            d.st = ST_SETUP;
            d.cnt = SETUP_CYC - 4'h1;
            d.byte_i = 1'b1;
            d.dout = q.wbuf[15:8];
          end
          else
          begin
            d.st = ST_IDLE;
            d.cs_n = 1'b1;
            d.doe = 1'b0;
            d.aack = 1'b1;
            d.ta = 1'b1;
            d.rdata = q.dma ? {16'h0000, q.rbuf} : {24'h00_0000, q.rbuf[7:0]};
            if (q.dma)
            begin
              // Acknowledge stays low across both halves of a stereo pair.
              d.mid_pair = ~q.mid_pair;
              d.pair_wr = q.wr;
              if (q.mid_pair)
              begin
                d.cak_n = 1'b1;
                d.pak_n = 1'b1;
              end
            end
          end
        end
      end
    endcase
    // Request rises set pending bits; a rise wins over a service clear.
    rise = q.s2[9:8] & ~q.prv;
    d.prv = q.s2[9:8];
    d.pend = (q.pend & ~clr) | rise;
    d.irq_n = ~(|d.pend | q.s2[10]);
    d.src = {q.s2[10], d.pend};
  end

  // State register with clock enable; reset is the processor hard reset.
  always_ff @(posedge clk)
  begin
    if (rst)
      q <= RST_VAL;
    else if (ce)
      q <= d;
  end

  assign codec_data_out = q.dout;
  assign codec_data_oe = q.doe;
  assign codec_addr = q.caddr;
  assign codec_cs_n = q.cs_n;
  assign codec_rd_n = q.rd_n;
  assign codec_wr_n = q.wr_n;
  assign capture_dma_ack_n = q.cak_n;
  assign playback_dma_ack_n = q.pak_n;
  assign codec_power_down_n = q.pd_n;
  assign bus.aack = q.aack;
  assign bus.ta = q.ta;
  assign bus.bus_transfer_error = q.bus_transfer_error;
  assign bus.rdata = q.rdata;
  assign bus.irq_n = q.irq_n;
  assign bus.irq_src = q.src;
endmodule

// [hdl/lcb_master.sv]
// Bus master end: turns user commands into processor bus accesses.
// Assumes the bridge answers every access it decodes with ta or tea.
module lcb_master
  import lcb_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  lcb_bus_if.master bus,
  input wire logic little_endian,
  input wire logic cmd_valid,
  input wire lcb_cmd_e cmd_kind,
  input wire logic [1:0] cmd_reg,
  input wire logic [31:0] cmd_data,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [31:0] rsp_data,
  output logic rsp_err
);
  typedef enum logic [0:0] {HS_IDLE, HS_WAIT} lcb_ms_state_e;

  typedef struct packed {
    lcb_ms_state_e st;
    logic pair;
    logic half;
    logic [15:0] hi;
    logic ts;
    logic [31:0] addr;
    lcb_size_e size;
    logic write;
    logic [31:0] wdata;
    logic ready;
    logic rv;
    logic [31:0] rd;
    logic err;
  } lcb_ms_s;

  localparam lcb_ms_s RST_VAL = '{st: HS_IDLE, pair: 1'b0, half: 1'b0, hi: 16'h0000, ts: 1'b0,
    addr: 32'h0000_0000, size: SZ_BYTE, write: 1'b0, wdata: 32'h0000_0000, ready: 1'b0,
    rv: 1'b0, rd: 32'h0000_0000, err: 1'b0};

  lcb_ms_s q;
  lcb_ms_s d;
  logic [2:0] lo;

  // Command decode and the back-to-back issue of stereo pair halves.
  always_comb
  begin
    d = q;
    d.ts = 1'b0;
    d.rv = 1'b0;
    lo = 3'h0;
    unique case (q.st)
      HS_IDLE:
      begin
        if (cmd_valid && q.ready)
        begin
          d.ready = 1'b0;
          d.st = HS_WAIT;
          d.ts = 1'b1;
          d.half = 1'b0;
          d.hi = cmd_data[31:16];
          d.pair = cmd_kind == CMD_PAIR_RD || cmd_kind == CMD_PAIR_WR;
          d.write = cmd_kind == CMD_REG_WR || cmd_kind == CMD_PAIR_WR;
          d.addr = 32'h0000_0000;
          if (d.pair)
          begin
            // Little-endian mode flips low lines; the physical address must stay put.
            lo = little_endian ? LE_HALF_XOR : 3'h0;
            d.addr[RGN_HI:RGN_LO] = RGN_DMA;
            d.size = SZ_HALF;
            d.wdata = {16'h0000, cmd_data[15:0]};
          end
          else if (cmd_kind == CMD_REG_RD || cmd_kind == CMD_REG_WR)
          begin
            lo = little_endian ? LE_BYTE_XOR : 3'h0;
            d.addr[RGN_HI:RGN_LO] = RGN_REG;
            d.addr[SEL_HI:SEL_LO] = cmd_reg;
            d.size = SZ_BYTE;
            d.wdata = {24'h00_0000, cmd_data[7:0]};
          end
          else
          begin
            d.addr[RGN_HI:RGN_LO] = cmd_kind == CMD_PWR_DN ? RGN_PDN : RGN_PUP;
            d.size = SZ_WORD;
            d.wdata = 32'h0000_0000;
          end
          d.addr[LOW_HI:0] = lo;
        end
        else
          d.ready = 1'b1;
      end
      HS_WAIT:
      begin
        if (bus.ta || bus.bus_transfer_error)
        begin
          if (q.pair && !q.half && !bus.bus_transfer_error)
          begin
            // Second half goes out on the very next cycle.
            d.half = 1'b1;
            d.ts = 1'b1;
            d.wdata = {16'h0000, q.hi};
            d.rd = {16'h0000, bus.rdata[15:0]};
          end
          else
          begin
            d.st = HS_IDLE;
            d.ready = 1'b1;
            d.rv = 1'b1;
            d.err = bus.bus_transfer_error;
            d.rd = q.half ? {bus.rdata[15:0], q.rd[15:0]} : bus.rdata;
          end
        end
      end
    endcase
  end

  // State register with clock enable.
  always_ff @(posedge clk)
  begin
    if (rst)
      q <= RST_VAL;
    else if (ce)
      q <= d;
  end

  assign bus.ts = q.ts;
  assign bus.addr = q.addr;
  assign bus.size = q.size;
  assign bus.write = q.write;
  assign bus.wdata = q.wdata;
  assign cmd_ready = q.ready;
  assign rsp_valid = q.rv;
  assign rsp_data = q.rd;
  assign rsp_err = q.err;
endmodule

// [test/lcb_checker.sv]
// Concurrent checks on the bus joining the master and bridge ends, plus codec power and acks.
// Assumes one clock, a synchronous active-high reset and legal traffic from the master end.
module lcb_checker
  import lcb_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ts,
  input wire logic [31:0] addr,
  input wire lcb_size_e size,
  input wire logic write,
  input wire logic aack,
  input wire logic ta,
  input wire logic bus_transfer_error,
  input wire logic irq_n,
  input wire logic [2:0] irq_src,
  input wire logic codec_power_down_n,
  input wire logic capture_dma_ack_n,
  input wire logic playback_dma_ack_n,
  input wire logic capture_dma_request
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] rg;
  logic pup_q;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Region nibble of the access in flight.
  assign rg = addr[RGN_HI:RGN_LO];
  // Remembers a release access, since power-down may lift one cycle after it.
  always_ff @(posedge clk)
  begin
    pup_q <= rst ? 1'b0 : (ts && rg == RGN_PUP);
  end
  a_pdn_region_six: assert property (ts && rg == RGN_PDN |-> ##[1:2] (!codec_power_down_n && ta))
    else $error("power-down access did not assert power-down");
  a_pdn_in_reset: assert property (disable iff (1'b0) rst |=> !codec_power_down_n)
    else $error("power-down not asserted by reset");
  a_pup_region_seven: assert property (ts && rg == RGN_PUP |-> ##[1:2] (codec_power_down_n && ta))
    else $error("release access did not lift power-down");
  a_pdn_holds_low: assert property (!codec_power_down_n && !pup_q && !(ts && rg == RGN_PUP) |=> !codec_power_down_n)
    else $error("power-down lifted without a release access");
  a_reg_cycle_len: assert property (ts && rg == RGN_REG |=> !ta [*8] ##[13:15] (aack && ta))
    else $error("register access not answered after its codec cycle");
  a_dma_cycle_len: assert property (ts && rg == RGN_DMA |=> !ta [*8] ##[33:35] (aack && ta))
    else $error("stereo access not answered after two codec cycles");
  a_capture_ack_used: assert property (ts && rg == RGN_DMA && !write |-> ##[1:2] !capture_dma_ack_n)
    else $error("half-word load did not use the capture acknowledge");
  a_playback_ack_used: assert property (ts && rg == RGN_DMA && write |-> ##[1:2] !playback_dma_ack_n)
    else $error("half-word store did not use the playback acknowledge");
  a_acks_kept_apart: assert property (!(!capture_dma_ack_n && !playback_dma_ack_n))
    else $error("both channel acknowledges low together");
  a_request_raises_irq: assert property ($rose(capture_dma_request) |-> ##[2:4] (irq_src[0] && !irq_n))
    else $error("capture request did not raise the interrupt");
  a_sources_merged: assert property (irq_src != 3'h0 |-> ##[0:1] !irq_n)
    else $error("pending source not seen on the interrupt line");
  // Width discipline of the master end keeps the little-endian address swizzle predictable.
  a_reg_byte_size: assert property (ts && rg == RGN_REG |-> size == SZ_BYTE)
    else $error("register access issued with a non-byte width");
  a_dma_half_size: assert property (ts && rg == RGN_DMA |-> size == SZ_HALF)
    else $error("stereo access issued with a non-half-word width");
  a_answer_exclusive: assert property (!(ta && bus_transfer_error))
    else $error("transfer acknowledge and transfer error together");
endmodule

// [test/tb.sv]
// Bench: master and bridge joined by one bus; a second bridge is driven raw to break the rules.
// Assumes the bench itself plays the codec pins for both bridges.
module tb
  import lcb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, ce = 1, cv = 0, creq = 0, preq = 0, cint = 0, le = 0;
  logic rv, re, crdy, oe, cs_n, rd_n, wr_n, cak_n, pak_n, pdn_n, pdn2_n;
  lcb_cmd_e ck = CMD_PWR_UP;
  logic [1:0] cr = 2'h0, ca, ca2;
  logic [31:0] cd = 32'h0, rd;
  logic [7:0] din = 8'h0, dout;
  logic [7:0] rb[4];
  logic [7:0] wq[$];
  logic [1:0] aq[$];
  int failures = 0, checks = 0, rc = 0;
  lcb_bus_if bus (.clk(clk));
  lcb_bus_if bus2 (.clk(clk));
  lcb_master lcb_master_i (.clk(clk), .rst(rst), .ce(ce), .bus(bus), .little_endian(le), .cmd_valid(cv),
    .cmd_kind(ck), .cmd_reg(cr), .cmd_data(cd), .cmd_ready(crdy), .rsp_valid(rv), .rsp_data(rd), .rsp_err(re));
  lcb_bridge lcb_bridge_i (.clk(clk), .rst(rst), .ce(ce), .bus(bus), .codec_data_in(din), .codec_data_out(dout),
    .codec_data_oe(oe), .codec_addr(ca), .codec_cs_n(cs_n), .codec_rd_n(rd_n), .codec_wr_n(wr_n),
    .capture_dma_ack_n(cak_n), .playback_dma_ack_n(pak_n), .codec_power_down_n(pdn_n),
    .capture_dma_request(creq), .playback_dma_request(preq), .codec_int(cint));
  lcb_bridge lcb_bridge_i2 (.clk(clk), .rst(rst), .ce(ce), .bus(bus2), .codec_data_in(din), .codec_data_out(),
    .codec_data_oe(), .codec_addr(ca2), .codec_cs_n(), .codec_rd_n(), .codec_wr_n(), .capture_dma_ack_n(),
    .playback_dma_ack_n(), .codec_power_down_n(pdn2_n), .capture_dma_request(creq),
    .playback_dma_request(preq), .codec_int(cint));
  lcb_checker lcb_checker_i (.clk(clk), .rst(rst), .ts(bus.ts), .addr(bus.addr), .size(bus.size),
    .write(bus.write), .aack(bus.aack), .ta(bus.ta), .bus_transfer_error(bus.bus_transfer_error), .irq_n(bus.irq_n), .irq_src(bus.irq_src),
    .codec_power_down_n(pdn_n), .capture_dma_ack_n(cak_n), .playback_dma_ack_n(pak_n),
    .capture_dma_request(creq));
  // Free-running bus clock.
  initial
  begin
    forever #2 clk = ~clk;
  end
  // The codec hands out one table byte per read strobe; writes and selects are logged.
  always @(negedge rd_n)
  begin
    din <= rb[rc];
    rc <= rc + 1;
    chk(oe === 1'b0, "data bus driven during a read strobe");
  end
  always @(negedge wr_n)
  begin
    wq.push_back(dout);
    chk(oe === 1'b1, "data bus not driven during a write strobe");
  end
  // The select is logged at the strobe, a cycle after it settled, so it cannot race the chip-select edge.
  always @(negedge rd_n or negedge wr_n)
  begin
    if (cs_n === 1'b0)
      aq.push_back(ca);
  end
  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1)
    begin
      failures++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  task automatic conclude();
    if (failures == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Hands one command to the master end and waits, bounded, for its response pulse.
  task automatic cmd(input lcb_cmd_e k, input logic [1:0] r, input logic [31:0] d);
    int n;
    @(posedge clk);
    #1 cv = 1;
    ck = k;
    cr = r;
    cd = d;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (crdy !== 1'b1 && n < 200);
    #1 cv = 0;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rv !== 1'b1 && n < 200);
    chk(rv === 1'b1, "no response from master");
  endtask
  // One raw access on the second bus; ts is a one-cycle pulse, the rest holds until the answer.
  task automatic raw(input logic [31:0] a, input lcb_size_e s, input logic w, output logic ok, output logic er);
    int n;
    @(posedge clk);
    #1 bus2.ts = 1;
    bus2.addr = a;
    bus2.size = s;
    bus2.write = w;
    bus2.wdata = $urandom;
    @(posedge clk);
    #1 bus2.ts = 0;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (bus2.aack !== 1'b1 && n < 100);
    ok = bus2.ta;
    er = bus2.bus_transfer_error;
  endtask
  // Main sequence.
  initial
  begin
    logic ok, er;
    logic [31:0] v;
    void'($urandom(32'h09245eed));
    bus2.ts = 0;
    bus2.addr = 32'h0;
    bus2.size = SZ_BYTE;
    bus2.write = 1'b0;
    bus2.wdata = 32'h0;
    repeat (16) @(posedge clk);
    chk(pdn_n === 1'b0, "power-down not low in reset");
    #1 rst = 0;
    cmd(CMD_PWR_UP, 2'h0, 32'h0);
    chk(re === 1'b0 && pdn_n === 1'b1, "release access failed");
    cmd(CMD_PWR_DN, 2'h0, 32'h0);
    chk(re === 1'b0 && pdn_n === 1'b0, "power-down access failed");
    cmd(CMD_REG_RD, 2'h2, 32'h0);
    chk(pdn_n === 1'b0, "power-down lifted by a register access");
    cmd(CMD_PWR_UP, 2'h0, 32'h0);
    // Every register, both directions, random data, in both byte-order modes.
    for (int i = 0; i < 16; i++)
    begin
      #1 le = i[3];
      v = $urandom;
      rb[0] = v[15:8];
      rc = 0;
      wq.delete();
      aq.delete();
      cmd(i[0] ? CMD_REG_RD : CMD_REG_WR, i[2:1], v);
      chk(re === 1'b0 && aq.size() == 1 && aq[0] === i[2:1], "register select wrong");
      if (i[0])
        chk(rd[7:0] === v[15:8], "register read data wrong");
      else
        chk(wq.size() == 1 && wq[0] === v[7:0], "register write data wrong");
    end
    // A request raises the interrupt, then a stereo pair of that channel serves and clears it.
    for (int i = 0; i < 8; i++)
    begin
      v = $urandom;
      rb = '{v[7:0], v[15:8], v[23:16], v[31:24]};
      rc = 0;
      wq.delete();
      #1 creq = i[0];
      preq = !i[0];
      le = i[2];
      repeat (6) @(posedge clk);
      chk(bus.irq_n === 1'b0 && bus.irq_src === (i[0] ? 3'h1 : 3'h2), "request not raised");
      #1 creq = 0;
      preq = 0;
      cmd(i[0] ? CMD_PAIR_RD : CMD_PAIR_WR, 2'h0, v);
      chk(re === 1'b0 && bus.irq_src === 3'h0 && bus.irq_n === 1'b1, "pair failed or left pending");
      if (i[0])
        chk(rd === v, "stereo capture data wrong");
      else
        chk(wq.size() == 4 && {wq[3], wq[2], wq[1], wq[0]} === v, "playback byte order wrong");
    end
    #1 cint = 1;
    repeat (4) @(posedge clk);
    chk(bus.irq_n === 1'b0 && bus.irq_src === 3'h4, "codec interrupt not merged");
    #1 cint = 0;
    repeat (4) @(posedge clk);
    chk(bus.irq_n === 1'b1, "interrupt line stuck low");
    // Rule-breaking, aliased and undecoded traffic on the second bridge.
    raw(32'h4abc_de00, SZ_HALF, 1'b1, ok, er);
    chk(ok === 1'b1, "first half refused");
    raw(32'h5000_0008, SZ_BYTE, 1'b0, ok, er);
    chk(er === 1'b1, "intruding register access accepted");
    raw(32'h4000_0000, SZ_HALF, 1'b0, ok, er);
    chk(er === 1'b1, "opposite direction half accepted");
    raw(32'h4fff_ff00, SZ_HALF, 1'b1, ok, er);
    chk(ok === 1'b1, "second half refused");
    raw(32'h4000_0001, SZ_BYTE, 1'b0, ok, er);
    chk(er === 1'b1, "mono access accepted");
    raw(32'h5000_0000, SZ_HALF, 1'b0, ok, er);
    chk(er === 1'b1, "wide register access accepted");
    raw(32'h5a5a_5a10, SZ_BYTE, 1'b1, ok, er);
    chk(ok === 1'b1 && ca2 === SEL_STATUS, "aliased register missed");
    raw(32'h7123_4567, SZ_WORD, 1'b0, ok, er);
    chk(ok === 1'b1 && pdn2_n === 1'b1, "aliased release missed");
    raw(32'h6fed_cba9, SZ_BYTE, 1'b1, ok, er);
    chk(ok === 1'b1 && pdn2_n === 1'b0, "aliased power-down missed");
    raw(32'h1234_5678, SZ_WORD, 1'b0, ok, er);
    chk(ok === 1'b0 && er === 1'b0, "undecoded access answered");
    conclude();
  end
  // Cuts a hang short well beyond the fewer than two thousand cycles the sequence needs.
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    $display("MISMATCH %0t watchdog expired", $time);
    conclude();
  end
endmodule
